/* File: verilog/vtf_map.vh */
`ifndef VTF_MAP_VH
`define VTF_MAP_VH
// Register byte offsets on the Avalon-MM slave.
`define VTF_A_PSEL 8'h00
`define VTF_A_PCFG 8'h04
`define VTF_A_VSEL 8'h08
`define VTF_A_MEMB 8'h0C
`define VTF_A_STAT 8'h10
`define VTF_A_DROP 8'h14
`define VTF_A_FWD 8'h18
// Port configuration word fields.
`define VTF_PCFG_VID_HI 11
`define VTF_PCFG_TAG 12
`define VTF_PCFG_FILT 13
`define VTF_PCFG_PRI_LO 14
`define VTF_PCFG_PRI_HI 16
// Frame format constants.
`define VTF_TPID 16'h8100
`define VTF_VID_DEF 12'h001
`define VTF_VID_NULL 12'h000
`define VTF_VID_RSV 12'hFFF
`define VTF_PRI_DEF 3'h0
`define VTF_TYPE_POS 11'h00C
`define VTF_TCI_POS 11'h00E
`define VTF_TAG_END 11'h010
`define VTF_TAG_LEN 11'h004
`define VTF_MIN_HDR 11'h00E
`define VTF_MIN_TAGGED 11'h012
`define VTF_MIN_LEN 11'h03C
`define VTF_FCS_LAST 2'h3
// Frame check sequence arithmetic.
`define VTF_CRC_INIT 32'hFFFFFFFF
`define VTF_CRC_POLY 32'hEDB88320
`endif

/* File: verilog/vtf_filter.v */
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "vtf_map.vh"
// Behaviour
// (R1) A frame is tagged exactly when its type field after source MAC is 0x8100.
// (R2) Inserted tag goes after source MAC, frame grows four octets, content kept.
// (R3) Tag control word is 3-bit priority, 1-bit CFI, 12-bit VLAN identifier.
// (R4) Twelve-bit identifiers distinguish up to 4094 VLANs; reserved values handled.
// (R5) After adding a tag a fresh FCS is computed over the longer frame.
// (R6) After removing a tag a fresh FCS is computed over the shorter frame.
// (R7) One default identifier per port; after reset all ports are in VLAN 1.
// (R8) Untagged frames classify to the receiving port's default identifier.
// (R9) Tagged frames forward by the tag identifier, not the port default.
// (R10) Frames go out only on ports that are members of the frame's VLAN.
// (R11) A port may belong to any number of VLANs in the membership table.
// (R12) Each port has its own tagging or untagging mode.
// (R13) Tagging ports add a tag to untagged frames, pass tagged frames unchanged.
// (R14) Untagging ports strip tags and leave untagged frames unchanged.
// (R15) Ingress filtering is enabled per port and only then checks reception.
// (R16) Filtering drops tagged frames whose receiving port is not a VLAN member.
// (R17) Filtering drops tagged frames whose destination port is not a member.
// (R18) Filtering tags untagged frames with the default identifier on tagging ports.
// (R19) Filtering forwards untagged frames only to members of the receiving VLAN.
// (R20) Broadcasts reach only ports that are members of the receiving VLAN.
module vtf_filter #(
	parameter NP = 12,
	parameter PW = 4,
	parameter LW = 11,
	parameter MAXB = 2048
) (
	input wire clk,
	input wire rst_n,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire rx_valid,
	input wire [7:0] rx_data,
	input wire rx_last,
	input wire [PW-1:0] rx_port,
	input wire [NP-1:0] rx_dst,
	output wire rx_ready,
	output reg tx_valid,
	output reg [7:0] tx_data,
	output reg tx_last,
	output reg [PW-1:0] tx_port,
	input wire tx_ready
);

	// One-hot states of the frame engine.
	localparam S_INIT = 6'b000001;
	localparam S_RX = 6'b000010;
	localparam S_LOOK = 6'b000100;
	localparam S_PICK = 6'b001000;
	localparam S_TX = 6'b010000;
	localparam S_FCS = 6'b100000;

	// Merges a bus write into an old word lane by lane.
	function [31:0] bem;
		input [31:0] old;
		input [31:0] wd;
		input [3:0] be;
		integer b;
		begin
			bem = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (be[b]) begin
					bem[b*8 +: 8] = wd[b*8 +: 8];
				end
			end
		end
	endfunction

	// Advances the reflected Ethernet CRC by one byte.
	function [31:0] crc8;
		input [31:0] c;
		input [7:0] d;
		integer i;
		begin
			crc8 = c;
			for (i = 0; i < 8; i = i + 1) begin
				if (crc8[0] ^ d[i]) begin
					crc8 = (crc8 >> 1) ^ `VTF_CRC_POLY;
				end else begin
					crc8 = crc8 >> 1;
				end
			end
		end
	endfunction

	// Index of the lowest set bit of a port mask.
	function [PW-1:0] lowidx;
		input [NP-1:0] m;
		integer i;
		begin
			lowidx = {PW{1'b0}};
			for (i = NP - 1; i >= 0; i = i - 1) begin
				if (m[i]) begin
					lowidx = i[PW-1:0];
				end
			end
		end
	endfunction

	// Frame store, VLAN membership table and per-port settings.
	reg [7:0] fbuf [0:MAXB-1];
	reg [NP-1:0] vtbl [0:4095];
	reg [11:0] port_default_vlan_id_r [0:NP-1];
	reg [2:0] pri_r [0:NP-1];
	reg [NP-1:0] tagm_r;
	reg [NP-1:0] filt_r;
	reg [PW-1:0] psel_r;
	reg [11:0] vsel_r;
	reg ack_r;
	// Working state of the frame engine for the stored frame and its copies.
	reg [5:0] st_r;
	reg [11:0] icnt_r;
	reg [LW-1:0] wr_r;
	reg [LW-1:0] len_r;
	reg [LW-1:0] oi_r;
	reg ovf_r;
	reg [PW-1:0] sp_r;
	reg [NP-1:0] dst_r;
	reg [NP-1:0] pend_r;
	reg [15:0] et_r;
	reg [15:0] tci_r;
	reg otag_r;
	reg [31:0] crc_r;
	reg [1:0] fc_r;
	reg [15:0] drop_r;
	reg [15:0] fwd_r;
	reg [7:0] obyte;
	reg [LW-1:0] src;
	integer k;

	// Classification of the stored frame.
	wire in_tag = (et_r == `VTF_TPID); // R1
	wire [11:0] tvid = tci_r[11:0]; // R3
	wire [11:0] cvid = (in_tag && tvid != `VTF_VID_NULL) ? tvid : port_default_vlan_id_r[sp_r]; // R8 R9
	wire [NP-1:0] memb = vtbl[cvid]; // R11
	wire bad = ovf_r || (len_r < `VTF_MIN_HDR) ||
		(in_tag && (len_r < `VTF_MIN_TAGGED || tvid == `VTF_VID_RSV)); // R4
	wire ing_rej = filt_r[sp_r] && in_tag && !memb[sp_r]; // R15 R16
	wire [NP-1:0] okm = (bad || ing_rej) ? {NP{1'b0}} : (dst_r & memb); // R10 R17 R19 R20
	wire [15:0] otci = in_tag ? tci_r : {pri_r[sp_r], 1'b0, cvid}; // R3 R18
	wire [PW-1:0] pidx = lowidx(pend_r);
	wire addt = !in_tag && otag_r;
	wire strip = in_tag && !otag_r;
	wire [LW-1:0] olen = addt ? len_r + `VTF_TAG_LEN : (strip ? len_r - `VTF_TAG_LEN : len_r);
	wire [LW-1:0] tend = (olen < `VTF_MIN_LEN) ? `VTF_MIN_LEN : olen;
	wire [31:0] fcs = ~crc_r;
	wire busy_init = (st_r == S_INIT);
	wire tx_free = !tx_valid || tx_ready;

	// Register words merged with the written byte lanes; each target keeps only its own bits.
	wire [31:0] psel_wm = bem({{(32-PW){1'b0}}, psel_r}, avs_writedata, avs_byteenable);
	wire [31:0] vsel_wm = bem({20'h00000, vsel_r}, avs_writedata, avs_byteenable);
	// Selected port configuration; a selector past the last port reads as zero.
	wire [31:0] pcfg_old = (psel_r < NP) ?
		{15'h0, pri_r[psel_r], filt_r[psel_r], tagm_r[psel_r], port_default_vlan_id_r[psel_r]} :
		32'h00000000;
	wire [31:0] pcfg_wm = bem(pcfg_old, avs_writedata, avs_byteenable);
	wire [31:0] memb_wm = bem({{(32-NP){1'b0}}, vtbl[vsel_r]}, avs_writedata,
		avs_byteenable);
	// Tag protocol identifier, split into its two bytes when a tag is inserted.
	wire [15:0] tpid_w = `VTF_TPID;

	assign rx_ready = (st_r == S_RX);
	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

	// Output byte at position oi_r: tag inserted or removed after the source MAC.
	always @* begin
		obyte = 8'h00;
		src = oi_r;
		if (strip && oi_r >= `VTF_TYPE_POS) begin
			src = oi_r + `VTF_TAG_LEN; // R14
		end
		if (addt && oi_r >= `VTF_TAG_END) begin
			src = oi_r - `VTF_TAG_LEN; // R2
		end
		if (oi_r < olen) begin
			obyte = fbuf[src];
			if (addt && oi_r >= `VTF_TYPE_POS && oi_r < `VTF_TAG_END) begin
				case (oi_r - `VTF_TYPE_POS)
					11'h000: obyte = tpid_w[15:8]; // R2
					11'h001: obyte = tpid_w[7:0];
					11'h002: obyte = otci[15:8]; // R13
					default: obyte = otci[7:0];
				endcase
			end
		end
	end

	// Frame store write port.
	always @(posedge clk) begin
		if (st_r == S_RX && rx_valid && !ovf_r) begin
			fbuf[wr_r] <= rx_data;
		end
	end

	// Membership table: cleared to VLAN 1 on every port, then written by software.
	always @(posedge clk) begin
		if (busy_init) begin
			vtbl[icnt_r] <= (icnt_r == `VTF_VID_DEF) ? {NP{1'b1}} : {NP{1'b0}}; // R7
		end else if (avs_write && ack_r && avs_address == `VTF_A_MEMB) begin
			vtbl[vsel_r] <= memb_wm[NP-1:0]; // R11
		end
	end

	// Avalon slave: one wait cycle once the table sweep is done, read data registered, write on the final edge.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
			avs_readdata <= 32'h00000000;
			psel_r <= {PW{1'b0}};
			vsel_r <= `VTF_VID_DEF;
			tagm_r <= {NP{1'b0}};
			filt_r <= {NP{1'b0}};
			for (k = 0; k < NP; k = k + 1) begin
				port_default_vlan_id_r[k] <= `VTF_VID_DEF; // R7
				pri_r[k] <= `VTF_PRI_DEF;
			end
		end else begin
			// Acknowledge in the cycle after a request, never during the table sweep.
			ack_r <= (avs_read || avs_write) && !ack_r && !busy_init;
			// Read data is captured in the wait cycle and stands at the completion edge.
			if (avs_read && !ack_r) begin
				case (avs_address)
					`VTF_A_PSEL: avs_readdata <= {{(32-PW){1'b0}}, psel_r};
					`VTF_A_PCFG: avs_readdata <= pcfg_old;
					`VTF_A_VSEL: avs_readdata <= {20'h00000, vsel_r};
					`VTF_A_MEMB: avs_readdata <= {{(32-NP){1'b0}}, vtbl[vsel_r]};
					`VTF_A_STAT: avs_readdata <= {30'h0, !rx_ready, busy_init};
					`VTF_A_DROP: avs_readdata <= {16'h0000, drop_r};
					`VTF_A_FWD: avs_readdata <= {16'h0000, fwd_r};
					default: avs_readdata <= 32'h00000000;
				endcase
			end
			// Writes land on the completion edge, byte lane by byte lane.
			if (avs_write && ack_r) begin
				case (avs_address)
					`VTF_A_PSEL: psel_r <= psel_wm[PW-1:0];
					`VTF_A_VSEL: vsel_r <= vsel_wm[`VTF_PCFG_VID_HI:0];
					`VTF_A_PCFG: begin
						if (psel_r < NP) begin
							port_default_vlan_id_r[psel_r] <= pcfg_wm[`VTF_PCFG_VID_HI:0]; // R7
							tagm_r[psel_r] <= pcfg_wm[`VTF_PCFG_TAG]; // R12
							filt_r[psel_r] <= pcfg_wm[`VTF_PCFG_FILT]; // R15
							pri_r[psel_r] <= pcfg_wm[`VTF_PCFG_PRI_HI:`VTF_PCFG_PRI_LO];
						end
					end
					default: ack_r <= 1'b0;
				endcase
			end
		end
	end

	// Frame engine: store, classify, then replay once per destination port.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= S_INIT;
			icnt_r <= 12'h000;
			wr_r <= {LW{1'b0}};
			len_r <= {LW{1'b0}};
			oi_r <= {LW{1'b0}};
			ovf_r <= 1'b0;
			sp_r <= {PW{1'b0}};
			dst_r <= {NP{1'b0}};
			pend_r <= {NP{1'b0}};
			et_r <= 16'h0000;
			tci_r <= 16'h0000;
			otag_r <= 1'b0;
			crc_r <= `VTF_CRC_INIT;
			fc_r <= 2'h0;
			drop_r <= 16'h0000;
			fwd_r <= 16'h0000;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			tx_last <= 1'b0;
			tx_port <= {PW{1'b0}};
		end else begin
			if (tx_ready) begin
				tx_valid <= 1'b0;
			end
			case (st_r)
				// Sweep the table so that only VLAN 1 has members before traffic is taken.
				S_INIT: begin
					icnt_r <= icnt_r + 12'h001;
					if (icnt_r == `VTF_VID_RSV) begin
						st_r <= S_RX;
					end
				end
				// Store the frame and latch its type, tag and forwarding inputs.
				S_RX: begin
					if (rx_valid) begin
						if (wr_r == {LW{1'b0}}) begin
							sp_r <= rx_port;
							dst_r <= rx_dst;
						end
						if (wr_r == `VTF_TYPE_POS) et_r[15:8] <= rx_data; // R1
						if (wr_r == `VTF_TYPE_POS + 11'h001) et_r[7:0] <= rx_data;
						if (wr_r == `VTF_TCI_POS) tci_r[15:8] <= rx_data; // R3
						if (wr_r == `VTF_TCI_POS + 11'h001) tci_r[7:0] <= rx_data;
						if (wr_r == MAXB - 1) begin
							ovf_r <= 1'b1;
						end else begin
							wr_r <= wr_r + 11'h001;
						end
						if (rx_last) begin
							len_r <= wr_r + 11'h001;
							wr_r <= {LW{1'b0}};
							st_r <= S_LOOK;
						end
					end
				end
				// Classify once and keep the set of ports that still owe a copy.
				S_LOOK: begin
					pend_r <= okm; // R10 R17 R19 R20
					if (okm == {NP{1'b0}}) begin
						drop_r <= drop_r + 16'h0001;
					end
					st_r <= S_PICK;
				end
				// Start the next copy on the lowest pending port, or reopen reception.
				S_PICK: begin
					if (tx_free) begin
						if (pend_r == {NP{1'b0}}) begin
							ovf_r <= 1'b0;
							et_r <= 16'h0000;
							st_r <= S_RX;
						end else begin
							pend_r <= pend_r & ~({{(NP-1){1'b0}}, 1'b1} << pidx);
							tx_port <= pidx;
							otag_r <= tagm_r[pidx]; // R12 R13 R14 R18
							oi_r <= {LW{1'b0}};
							crc_r <= `VTF_CRC_INIT;
							fc_r <= 2'h0;
							fwd_r <= fwd_r + 16'h0001;
							st_r <= S_TX;
						end
					end
				end
				// Replay the body with the egress tag treatment and zero padding.
				S_TX: begin
					if (tx_free) begin
						tx_valid <= 1'b1;
						tx_data <= obyte;
						tx_last <= 1'b0;
						crc_r <= crc8(crc_r, obyte); // R5 R6
						oi_r <= oi_r + 11'h001;
						if (oi_r == tend - 11'h001) begin
							st_r <= S_FCS;
						end
					end
				end
				// Append the fresh check sequence, low byte first.
				S_FCS: begin
					if (tx_free) begin
						tx_valid <= 1'b1;
						tx_data <= fcs[fc_r*8 +: 8]; // R5 R6
						tx_last <= (fc_r == `VTF_FCS_LAST);
						fc_r <= fc_r + 2'h1;
						if (fc_r == `VTF_FCS_LAST) begin
							st_r <= S_PICK;
						end
					end
				end
				default: st_r <= S_INIT;
			endcase
		end
	end

endmodule

/* File: verif/vtf_filter_sva.sv */
`timescale 1ns/1ps
// Checks the bus and frame handshakes of the VLAN filter at its ports.
module vtf_filter_sva #(
	parameter PW = 4
) (
	input wire clk,
	input wire rst_n,
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	input wire rx_valid,
	input wire rx_last,
	input wire rx_ready,
	input wire tx_valid,
	input wire [7:0] tx_data,
	input wire tx_last,
	input wire [PW-1:0] tx_port,
	input wire tx_ready
);
	reg [12:0] init_r;
	reg [6:0] len_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Counts edges since reset and bytes of the outgoing copy, both saturating.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			init_r <= 13'h0000;
			len_r <= 7'h00;
		end else begin
			init_r <= init_r + {12'h000, init_r != 13'h1FFF};
			if (tx_valid && tx_ready) begin
				len_r <= tx_last ? 7'h00 : len_r + {6'h00, len_r != 7'h7F};
			end
		end
	end
	chk_sweep_rx: assert property (init_r < 13'h0FA0 |-> !rx_ready)
		else $error("rx open during sweep");
	chk_idle_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait without request");
	chk_ack_time: assert property (
		init_r > 13'h1100 && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("late ack");
	chk_tx_hold: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data) && $stable(tx_last) && $stable(tx_port)) else $error("tx moved");
	chk_port_fixed: assert property (tx_valid && tx_ready && !tx_last |=> $stable(tx_port))
		else $error("port changed in copy");
	chk_rx_close: assert property (rx_valid && rx_ready && rx_last |=>
		(!rx_ready && !tx_valid) [*2]) else $error("no classify gap");
	chk_store_fwd: assert property (tx_valid |-> !rx_ready) else $error("rx during tx");
	chk_copy_min: assert property (tx_valid && tx_ready && tx_last |-> len_r >= 7'h3F)
		else $error("short copy");
endmodule

/* File: verif/vtf_mac_model.sv */
`timescale 1ns/1ps
// Port MACs and lookup: feeds one stored frame in and collects the copies sent out.
module vtf_mac_model (
	input wire clk,
	output reg rx_valid = 1'b0,
	output reg [7:0] rx_data = 8'h00,
	output reg rx_last = 1'b0,
	output reg [3:0] rx_port = 4'h0,
	output reg [11:0] rx_dst = 12'h000,
	input wire rx_ready,
	input wire tx_valid,
	input wire [7:0] tx_data,
	input wire tx_last,
	input wire [3:0] tx_port,
	output reg tx_ready = 1'b1
);
	reg [7:0] fr [0:255];
	reg [7:0] cap [0:255];
	reg [3:0] cap_port = 4'h0;
	reg slow = 1'b0;
	reg hung = 1'b0;
	integer cap_n = 0;
	integer copies = 0;
	// Takes each accepted byte; a slow sink stalls every other cycle.
	always @(posedge clk) begin
		tx_ready <= !slow || !tx_ready;
		if (tx_valid && tx_ready) begin
			cap[cap_n] <= tx_data;
			cap_n <= cap_n + 1;
			cap_port <= tx_port;
			copies <= copies + (tx_last ? 1 : 0);
		end
	end
	// Holds each byte until it is taken; released lines show the inverse of the last value.
	task send(input integer n, input [3:0] p, input [11:0] m);
		integer i, w;
		begin
			for (i = 0; i < n; i = i + 1) begin
				rx_valid <= 1'b1;
				rx_data <= fr[i];
				rx_last <= (i == n - 1);
				rx_port <= p;
				rx_dst <= m;
				w = 0;
				@(posedge clk);
				while (!rx_ready && !hung) begin
					@(posedge clk);
					w = w + 1;
					hung = (w >= 9000);
				end
			end
			rx_valid <= 1'b0;
			rx_last <= 1'b0;
			rx_data <= ~fr[n-1];
			rx_port <= ~p;
			rx_dst <= ~m;
		end
	endtask
endmodule

/* File: verif/vtf_filter_bench.sv */
`timescale 1ns/1ps
`include "vtf_map.vh"
module vtf_filter_bench;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg [7:0] avs_address = 8'h00;
	reg avs_read = 1'b0;
	reg avs_write = 1'b0;
	reg [31:0] avs_writedata = 32'h00000000;
	reg [3:0] avs_byteenable = 4'hF;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
	wire [7:0] rx_data, tx_data;
	wire [3:0] rx_port, tx_port;
	wire [11:0] rx_dst;
	reg [7:0] ex [0:255];
	reg [31:0] q;
	integer en, err_total = 0, tests_run = 0;
	vtf_filter #(.NP(12), .PW(4)) i_dut (.*);
	vtf_mac_model i_mac (.*);
	// Free-running system clock.
	initial forever #10 clk = ~clk;
	// Cuts a hung run short.
	initial begin
		#2000000;
		err_total = err_total + 1;
		stop_test;
	end
	task stop_test;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, err_total);
			if (err_total == 0 && tests_run > 0) begin
				$display("NO MISMATCHES");
			end else begin
				$display("MISMATCHES SEEN");
			end
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] want);
		begin
			tests_run = tests_run + 1;
			if (got !== want) begin
				err_total = err_total + 1;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
			end
		end
	endtask
	// One Avalon transfer, held until waitrequest is seen low; read data lands in q.
	task bus(input wr, input [7:0] a, input [31:0] d);
		integer n;
		begin
			n = 0;
			avs_address <= a;
			avs_writedata <= d;
			avs_write <= wr;
			avs_read <= !wr;
			@(posedge clk);
			while (avs_waitrequest && n < 9000) begin
				@(posedge clk);
				n = n + 1;
			end
			if (n >= 9000) begin
				err_total = err_total + 1;
				stop_test;
			end
			q = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			@(posedge clk);
		end
	endtask
	// Builds a frame (tagged with vid if tg) and its copy: 0 same, 1 tag added, 2 tag removed.
	task mk(input integer n, input tg, input [11:0] vid, input integer mode);
		integer i, b;
		reg [31:0] c;
		begin
			for (i = 0; i < n; i = i + 1) begin
				i_mac.fr[i] = i[7:0] ^ 8'hA5;
			end
			if (tg) begin
				{i_mac.fr[12], i_mac.fr[13], i_mac.fr[14], i_mac.fr[15]} = {16'h8100, 4'h0, vid};
			end
			en = 0;
			for (i = 0; i < n; i = i + 1) begin
				if (mode == 1 && i == 12) begin
					{ex[12], ex[13], ex[14], ex[15]} = {16'h8100, 4'h0, vid};
					en = 16;
				end
				if (mode != 2 || i < 12 || i > 15) begin
					ex[en] = i_mac.fr[i];
					en = en + 1;
				end
			end
			for (i = en; i < 60; i = i + 1) begin
				ex[i] = 8'h00;
			end
			en = (en < 60) ? 60 : en;
			c = 32'hFFFFFFFF;
			for (i = 0; i < en; i = i + 1) begin
				c = c ^ {24'h000000, ex[i]};
				for (b = 0; b < 8; b = b + 1) begin
					c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
				end
			end
			{ex[en+3], ex[en+2], ex[en+1], ex[en]} = ~c;
			en = en + 4;
		end
	endtask
	// Sends the frame, waits for the engine to go idle and compares what came out.
	task run(input integer n, input [3:0] src, input [11:0] dst, input integer ncp, input [3:0] op);
		integer i, w;
		begin
			i_mac.cap_n = 0;
			i_mac.copies = 0;
			i_mac.send(n, src, dst);
			w = 0;
			@(posedge clk);
			while (!rx_ready && w < 5000) begin
				@(posedge clk);
				w = w + 1;
			end
			@(posedge clk);
			chk(w < 5000, 1);
			chk(i_mac.hung, 1'b0);
			if (w >= 5000 || i_mac.hung) begin
				stop_test;
			end
			chk(i_mac.copies, ncp);
			if (ncp > 0) begin
				chk(i_mac.cap_port, op);
				chk(i_mac.cap_n, en);
				for (i = 0; i < en; i = i + 1) begin
					chk(i_mac.cap[i], ex[i]);
				end
			end
		end
	endtask
	// Main sequence: defaults, then one frame per forwarding case.
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, `VTF_A_STAT, 0);
		chk(q[0], 0);
		bus(1'b0, `VTF_A_VSEL, 0);
		chk(q, 32'h00000001);
		bus(1'b0, `VTF_A_MEMB, 0);
		chk(q, 32'h00000FFF);
		bus(1'b0, `VTF_A_PCFG, 0);
		chk(q, 32'h00000001);
		bus(1'b0, 8'h1C, 0);
		chk(q, 32'h00000000);
		mk(20, 1'b0, 12'h000, 0);
		run(20, 4'h0, 12'h008, 1, 4'h3);
		bus(1'b1, `VTF_A_PCFG, 32'h00000005);
		bus(1'b1, `VTF_A_VSEL, 32'h00000005);
		bus(1'b1, `VTF_A_MEMB, 32'h00000009);
		bus(1'b1, `VTF_A_PSEL, 32'h00000003);
		bus(1'b1, `VTF_A_PCFG, 32'h00001001);
		mk(64, 1'b0, 12'h005, 1);
		run(64, 4'h0, 12'h018, 1, 4'h3);
		bus(1'b1, `VTF_A_VSEL, 32'h00000007);
		bus(1'b1, `VTF_A_MEMB, 32'h00000010);
		i_mac.slow = 1'b1;
		mk(70, 1'b1, 12'h007, 2);
		run(70, 4'h0, 12'h018, 1, 4'h4);
		i_mac.slow = 1'b0;
		bus(1'b1, `VTF_A_PSEL, 32'h00000000);
		bus(1'b1, `VTF_A_PCFG, 32'h00002005);
		run(70, 4'h0, 12'h018, 0, 4'h0);
		bus(1'b1, `VTF_A_MEMB, 32'h00000011);
		run(70, 4'h0, 12'h008, 0, 4'h0);
		mk(70, 1'b1, 12'h005, 0);
		run(70, 4'h0, 12'h018, 1, 4'h3);
		mk(70, 1'b1, 12'hFFF, 0);
		run(70, 4'h0, 12'h018, 0, 4'h0);
		mk(20, 1'b0, 12'h000, 0);
		run(20, 4'h0, 12'h010, 0, 4'h0);
		mk(20, 1'b0, 12'h005, 1);
		run(20, 4'h0, 12'hFFE, 1, 4'h3);
		bus(1'b0, `VTF_A_DROP, 0);
		chk(q, 32'h00000004);
		bus(1'b0, `VTF_A_FWD, 0);
		chk(q, 32'h00000005);
		stop_test;
	end
endmodule
bind vtf_filter vtf_filter_sva #(.PW(PW)) i_sva (.*);
